// ### irq_logic_regs.vh
// Purpose: constants for the cpu interrupt logic
// Assumes: 20 MHz system clock, one domain
// Notes: register indices and bit positions
// What this block does
// - twelve sources, each with own flag
// - flags set regardless of any enable
// - bit 7 global enable gates the core request only
// - enabled flagged source requests vector on the next clock
// - reset clears the global enable
// - accept clears global enable, vector 0004h
// - return from irq sets global enable
// - external event latency three or four cycles
// - pin, port, timer flags in control register
// - peripheral flags gated by peripheral enable
// - pin edge chosen by option bit 6
// - pin flag bit 1, enable bit 4
// - pin wakes sleep; vector only if enabled
// - timer rollover sets bit 2, enable 5
// - port bits 7:4 change sets bit 0
// - only return address saved by hardware
// - mismatch keeps setting flag until port read
`ifndef IRQ_LOGIC_REGS_VH
`define IRQ_LOGIC_REGS_VH
// ********************
// register indices
// ********************
`define ADDR_IRQ_CONTROL 3'h0
`define ADDR_PERIPH_FLAG_ONE 3'h1
`define ADDR_PERIPH_FLAG_TWO 3'h2
`define ADDR_PERIPH_ENABLE_ONE 3'h3
`define ADDR_PERIPH_ENABLE_TWO 3'h4
`define ADDR_OPTION 3'h5
`define ADDR_IRQ_STATUS 3'h6
`define ADDR_IRQ_MASK 3'h7
// ********************
// fields
// ********************
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define BIT_TIMER_EN 5
`define BIT_EXT_EN 4
`define BIT_PORT_EN 3
`define BIT_TIMER_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PORT_FLAG 0
`define BIT_EDGE_SELECT 6
`define IRQ_VECTOR 13'h0004
`define CONTROL_RESET 8'h00
`define OPTION_RESET 8'hff
`define PERIPH_SOURCES 9
`endif

// ### sync_edge_flag.v
// Purpose: synchronised event flag with software clear
// Assumes: event input may be asynchronous
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module sync_edge_flag (
    input wire clk_sys,
    input wire rst_n,
    input wire event_in,
    input wire clear_req,
    output reg flag_r
);
    reg meta_r;
    reg sync_r;
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            flag_r <= 1'b0;
        end
        else
        begin
            meta_r <= event_in;
            sync_r <= meta_r;
            if (sync_r)
                flag_r <= 1'b1;
            else if (clear_req)
                flag_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### cpu_interrupt_logic.v
// Purpose: interrupt gathering, gating and vectoring for the core
// Assumes: one 20 MHz clock; core pulses accept and return strobes
// Notes: pin and port inputs synchronised by two flops
`timescale 1ns/1ps
`default_nettype none
`include "irq_logic_regs.vh"
module cpu_interrupt_logic (
    input wire clk_sys,
    input wire rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire ext_irq_pin,
    input wire [3:0] keypad_port,
    input wire keypad_port_read,
    input wire timer_zero_rollover,
    input wire [8:0] periph_event,
    input wire core_sleeping,
    input wire irq_accept,
    input wire return_from_irq,
    input wire [12:0] return_pc,
    output reg irq_request_r,
    output reg wake_r,
    output reg vector_load_r,
    output reg [12:0] vector_pc_r,
    output reg stack_push_r,
    output reg [12:0] stack_push_pc_r,
    output reg irq_out_r
);
    // ********************
    // input synchronisers
    // ********************
    reg ext_meta_r;
    reg ext_sync_r;
    reg ext_prev_r;
    reg [3:0] port_meta_r;
    reg [3:0] port_sync_r;
    reg [3:0] port_latch_r;
    reg tmr_meta_r;
    reg tmr_sync_r;
    reg tmr_prev_r;
    // prev resets low to match an idle low pin, so no false edge follows reset
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end
        else
        begin
            ext_meta_r <= ext_irq_pin;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            port_meta_r <= 4'h0;
            port_sync_r <= 4'h0;
        end
        else
        begin
            port_meta_r <= keypad_port;
            port_sync_r <= port_meta_r;
        end
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tmr_meta_r <= 1'b0;
            tmr_sync_r <= 1'b0;
            tmr_prev_r <= 1'b0;
        end
        else
        begin
            tmr_meta_r <= timer_zero_rollover;
            tmr_sync_r <= tmr_meta_r;
            tmr_prev_r <= tmr_sync_r;
        end
    end
    // ********************
    // registers
    // ********************
    reg [7:0] control_r;
    reg [7:0] option_r;
    reg [7:0] periph_en_one_r;
    reg [7:0] periph_en_two_r;
    reg [2:0] irq_status_r;
    reg [2:0] irq_mask_r;
    wire [8:0] periph_flag;
    // ********************
    // register decode
    // ********************
    wire wr_ctl = reg_wr && (reg_addr == `ADDR_IRQ_CONTROL);
    wire wr_pf_one = reg_wr && (reg_addr == `ADDR_PERIPH_FLAG_ONE);
    wire wr_pf_two = reg_wr && (reg_addr == `ADDR_PERIPH_FLAG_TWO);
    wire wr_pe_one = reg_wr && (reg_addr == `ADDR_PERIPH_ENABLE_ONE);
    wire wr_pe_two = reg_wr && (reg_addr == `ADDR_PERIPH_ENABLE_TWO);
    wire wr_opt = reg_wr && (reg_addr == `ADDR_OPTION);
    wire wr_sts = reg_wr && (reg_addr == `ADDR_IRQ_STATUS);
    wire wr_msk = reg_wr && (reg_addr == `ADDR_IRQ_MASK);
    // ********************
    // pin edge and timer rollover
    // ********************
    wire edge_rise = ext_sync_r && !ext_prev_r;
    wire edge_fall = !ext_sync_r && ext_prev_r;
    wire ext_edge = option_r[`BIT_EDGE_SELECT] ? edge_rise : edge_fall;
    wire tmr_event = tmr_sync_r && !tmr_prev_r;
    // ********************
    // port change
    // ********************
    // mismatch persists until the port is read, so the flag keeps setting
    wire port_mismatch = (port_sync_r != port_latch_r);
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            port_latch_r <= 4'h0;
        else if (keypad_port_read)
            port_latch_r <= port_sync_r;
    end
    // ********************
    // peripheral flags
    // ********************
    // nine peripheral sources plus three core sources make twelve
    genvar gi;
    generate
        for (gi = 0; gi < `PERIPH_SOURCES; gi = gi + 1)
        begin : g_periph
            wire clr;
            if (gi < 8)
            begin : g_one
                assign clr = wr_pf_one && !reg_wdata[gi];
            end
            else
            begin : g_two
                assign clr = wr_pf_two && !reg_wdata[gi-8];
            end
            sync_edge_flag u_flag (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .event_in(periph_event[gi]),
                .clear_req(clr),
                .flag_r(periph_flag[gi])
            );
        end
    endgenerate
    // ********************
    // request gating
    // ********************
    wire [15:0] periph_en = {periph_en_two_r, periph_en_one_r};
    wire periph_pending = |(periph_flag & periph_en[8:0]);
    wire ext_pending = control_r[`BIT_EXT_FLAG] && control_r[`BIT_EXT_EN];
    wire tmr_pending = control_r[`BIT_TIMER_FLAG] && control_r[`BIT_TIMER_EN];
    wire port_pending = control_r[`BIT_PORT_FLAG] && control_r[`BIT_PORT_EN];
    wire core_pending = ext_pending || tmr_pending || port_pending;
    wire any_pending = core_pending
        || (control_r[`BIT_PERIPH_EN] && periph_pending);
    // ********************
    // control register and vectoring
    // ********************
    reg [7:0] ctl_wr;
    reg [7:0] ctl_nxt;
    // software write first; hardware sets below override it
    always @*
    begin
        ctl_wr = control_r;
        if (wr_ctl)
            ctl_wr = reg_wdata;
    end
    always @*
    begin
        ctl_nxt = ctl_wr;
        // flag sets come after the write so the set wins
        if (ext_edge)
            ctl_nxt[`BIT_EXT_FLAG] = 1'b1;
        if (tmr_event)
            ctl_nxt[`BIT_TIMER_FLAG] = 1'b1;
        if (port_mismatch)
            ctl_nxt[`BIT_PORT_FLAG] = 1'b1;
        if (irq_accept)
            ctl_nxt[`BIT_GLOBAL_EN] = 1'b0;
        else if (return_from_irq)
            ctl_nxt[`BIT_GLOBAL_EN] = 1'b1;
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            control_r <= `CONTROL_RESET;
        else
            control_r <= ctl_nxt;
    end
    // edge polarity resets to rising
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            option_r <= `OPTION_RESET;
        else if (wr_opt)
            option_r <= reg_wdata;
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            periph_en_one_r <= 8'h00;
        else if (wr_pe_one)
            periph_en_one_r <= reg_wdata;
    end
    // only one source sits in the second bank; upper enables read zero
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            periph_en_two_r <= 8'h00;
        else if (wr_pe_two)
            periph_en_two_r <= {7'h00, reg_wdata[0]};
    end
    // ********************
    // core handshake outputs
    // ********************
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            irq_request_r <= 1'b0;
        else
            // request follows pending by one flop; with two sync flops
            // this keeps pin-to-vector within the core's cycle budget
            irq_request_r <= control_r[`BIT_GLOBAL_EN] && any_pending
                && !irq_accept;
    end
    // wake only needs the enable, not the global enable
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            wake_r <= 1'b0;
        else
            wake_r <= core_sleeping && any_pending;
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            vector_load_r <= 1'b0;
            vector_pc_r <= 13'h0000;
            stack_push_r <= 1'b0;
            stack_push_pc_r <= 13'h0000;
        end
        else
        begin
            vector_load_r <= irq_accept;
            vector_pc_r <= `IRQ_VECTOR;
            stack_push_r <= irq_accept;
            if (irq_accept)
                stack_push_pc_r <= return_pc;
        end
    end
    // ********************
    // event status and interrupt output
    // ********************
    wire [2:0] evt = {tmr_event, port_mismatch, ext_edge};
    reg [2:0] status_nxt;
    // events are or-ed in after the clear so a same-cycle event survives
    always @*
    begin
        status_nxt = irq_status_r;
        if (wr_sts)
            status_nxt = irq_status_r & ~reg_wdata[2:0];
        status_nxt = status_nxt | evt;
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            irq_status_r <= 3'h0;
        else
            irq_status_r <= status_nxt;
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            irq_mask_r <= 3'h0;
        else if (wr_msk)
            irq_mask_r <= reg_wdata[2:0];
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            irq_out_r <= 1'b0;
        else
            irq_out_r <= |(irq_status_r & irq_mask_r);
    end
    // ********************
    // read port
    // ********************
    reg [7:0] rdata_nxt;
    // the data slot is zero outside the cycle after a read strobe
    always @*
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == `ADDR_IRQ_CONTROL)
                rdata_nxt = control_r;
            else if (reg_addr == `ADDR_PERIPH_FLAG_ONE)
                rdata_nxt = periph_flag[7:0];
            else if (reg_addr == `ADDR_PERIPH_FLAG_TWO)
                rdata_nxt = {7'h00, periph_flag[8]};
            else if (reg_addr == `ADDR_PERIPH_ENABLE_ONE)
                rdata_nxt = periph_en_one_r;
            else if (reg_addr == `ADDR_PERIPH_ENABLE_TWO)
                rdata_nxt = periph_en_two_r;
            else if (reg_addr == `ADDR_OPTION)
                rdata_nxt = option_r;
            else if (reg_addr == `ADDR_IRQ_STATUS)
                rdata_nxt = {5'h00, irq_status_r};
            else
                rdata_nxt = {5'h00, irq_mask_r};
        end
    end
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_nxt;
    end
endmodule
`default_nettype wire

// ### cpu_interrupt_logic_monitor.sv
// Purpose: port checker for the cpu interrupt logic
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_logic_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic core_sleeping,
    input wire logic irq_accept,
    input wire logic [12:0] return_pc,
    input wire logic irq_request_r,
    input wire logic wake_r,
    input wire logic vector_load_r,
    input wire logic [12:0] vector_pc_r,
    input wire logic stack_push_r,
    input wire logic [12:0] stack_push_pc_r
);
    // ********************
    // checks
    // ********************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_vector_addr: assert property (vector_load_r |-> vector_pc_r == 13'h0004)
        else $error("vector address wrong");
    a_accept_push: assert property (irq_accept |=> stack_push_r && vector_load_r)
        else $error("no push after accept");
    a_push_only_accept: assert property (!irq_accept |=> !stack_push_r && !vector_load_r)
        else $error("push without accept");
    a_push_pc: assert property (irq_accept |=> stack_push_pc_r == $past(return_pc))
        else $error("pushed pc wrong");
    a_gie_drop: assert property (irq_accept |-> ##2 !irq_request_r)
        else $error("request held after accept");
    a_reset_quiet: assert property ($rose(rst_n) |-> !irq_request_r [*2])
        else $error("request after reset");
    a_wake_sleep: assert property (wake_r |-> $past(core_sleeping))
        else $error("wake while awake");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
endmodule
`default_nettype wire

// ### core_model.sv
// Purpose: processor core stand-in that accepts requests
// Assumes: accept pulse may be delayed by slow cycles
// Notes: accepts once per request, rearms when it drops
`timescale 1ns/1ps
`default_nettype none
module core_model #(parameter logic [12:0] PC = 13'h0123) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic irq_request_r,
    input wire logic accept_en,
    input wire logic [3:0] slow,
    output logic irq_accept,
    output logic [12:0] return_pc,
    output logic [7:0] n_acc
);
    // ********************
    // accept logic
    // ********************
    logic armed_r;
    logic [3:0] cnt_r;
    wire fire = armed_r && accept_en && irq_request_r && cnt_r == slow;
    assign return_pc = PC;
    // rearm only on a low request, so a stuck request is not taken twice
    always @(posedge clk_sys)
    begin
        irq_accept <= rst_n && fire;
        armed_r <= !rst_n || !irq_request_r || (armed_r && !fire);
        cnt_r <= (!rst_n || !irq_request_r) ? 4'h0 : cnt_r + {3'h0, armed_r && accept_en};
        n_acc <= !rst_n ? 8'h00 : n_acc + {7'h00, irq_accept};
    end
endmodule
`default_nettype wire

// ### cpu_interrupt_logic_tb.sv
// Purpose: self-checking bench for the cpu interrupt logic
// Assumes: core model answers requests
// Notes: expectations come from the control bit map
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_logic_tb;
    // ********************
    // bench
    // ********************
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ext_irq_pin = 1'b0;
    logic keypad_port_read = 1'b0;
    logic timer_zero_rollover = 1'b0;
    logic core_sleeping = 1'b0;
    logic return_from_irq = 1'b0;
    logic accept_en = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [3:0] keypad_port = 4'h0;
    logic [3:0] slow = 4'h0;
    logic [8:0] periph_event = 9'h000;
    logic [7:0] reg_rdata, rd_val, n_acc;
    logic [12:0] return_pc, vector_pc_r, stack_push_pc_r;
    logic irq_accept, irq_request_r, wake_r, vector_load_r, stack_push_r, irq_out_r;
    int n_fail = 0;
    int num_checks = 0;
    int lat;
    always #25 clk_sys = ~clk_sys;
    cpu_interrupt_logic i_cpu_interrupt_logic (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .ext_irq_pin, .keypad_port, .keypad_port_read,
        .timer_zero_rollover, .periph_event, .core_sleeping, .irq_accept, .return_from_irq,
        .return_pc, .irq_request_r, .wake_r, .vector_load_r, .vector_pc_r, .stack_push_r,
        .stack_push_pc_r, .irq_out_r);
    core_model i_core_model (.clk_sys, .rst_n, .irq_request_r, .accept_en, .slow,
        .irq_accept, .return_pc, .n_acc);
    task close_out;
    begin
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task chk(input string nm, input [12:0] seen, input [12:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task wr(input [2:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [2:0] a);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    end
    endtask
    // bounded wait on wake (w=1) or request (w=0)
    task waitc(input bit w);
    begin
        lat = 0;
        while ((w ? wake_r : irq_request_r) !== 1'b1)
        begin
            @(posedge clk_sys);
            #1 lat++;
            if (lat > 40)
            begin
                n_fail++;
                close_out;
            end
        end
    end
    endtask
    task ret;
    begin
        return_from_irq <= 1'b1;
        @(posedge clk_sys);
        return_from_irq <= 1'b0;
    end
    endtask
    task t_reset;
    begin
        rd(3'h0);
        chk("ctl", rd_val, 8'h00);
        rd(3'h5);
        chk("opt", rd_val, 8'hff);
        wr(3'h0, 8'h80);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(3'h0);
        chk("ctl", rd_val, 8'h00);
        $display("done reset");
    end
    endtask
    task t_ext;
    begin
        wr(3'h0, 8'h10);
        core_sleeping <= 1'b1;
        ext_irq_pin <= 1'b1;
        waitc(1'b1);
        chk("req", irq_request_r, 1'b0);
        rd(3'h0);
        chk("ctl", rd_val, 8'h12);
        rd(3'h6);
        chk("sts", rd_val, 8'h01);
        wr(3'h7, 8'h01);
        core_sleeping <= 1'b0;
        rd(3'h7);
        chk("irq", irq_out_r, 1'b1);
        wr(3'h6, 8'h01);
        rd(3'h6);
        chk("sts", rd_val, 8'h00);
        chk("irq", irq_out_r, 1'b0);
        wr(3'h0, 8'h92);
        waitc(1'b0);
        repeat (4) @(posedge clk_sys);
        rd(3'h0);
        chk("ctl", rd_val, 8'h12);
        chk("pc", stack_push_pc_r, 13'h0123);
        chk("acc", n_acc, 8'h01);
        wr(3'h0, 8'h10);
        ret;
        rd(3'h0);
        chk("ctl", rd_val, 8'h90);
        chk("req", irq_request_r, 1'b0);
        $display("done ext");
    end
    endtask
    task t_lat;
    begin
        wr(3'h5, 8'hbf);
        slow <= 4'h5;
        ext_irq_pin <= 1'b0;
        waitc(1'b0);
        chk("lat", lat >= 3 && lat <= 4, 1'b1);
        repeat (10) @(posedge clk_sys);
        chk("acc", n_acc, 8'h02);
        wr(3'h0, 8'h10);
        ret;
        $display("done latency");
    end
    endtask
    task t_src;
    begin
        wr(3'h0, 8'h00);
        timer_zero_rollover <= 1'b1;
        periph_event <= 9'h001;
        keypad_port <= 4'h5;
        @(posedge clk_sys);
        timer_zero_rollover <= 1'b0;
        periph_event <= 9'h000;
        repeat (3) @(posedge clk_sys);
        rd(3'h0);
        chk("ctl", rd_val, 8'h05);
        rd(3'h1);
        chk("pf1", rd_val, 8'h01);
        wr(3'h0, 8'h00);
        rd(3'h0);
        chk("ctl", rd_val, 8'h01);
        @(posedge clk_sys);
        keypad_port_read <= 1'b1;
        @(posedge clk_sys);
        keypad_port_read <= 1'b0;
        wr(3'h0, 8'h00);
        rd(3'h0);
        chk("ctl", rd_val, 8'h00);
        wr(3'h3, 8'h01);
        wr(3'h0, 8'h80);
        rd(3'h0);
        chk("req", irq_request_r, 1'b0);
        wr(3'h0, 8'hc0);
        waitc(1'b0);
        wr(3'h1, 8'hfe);
        rd(3'h1);
        chk("pf1", rd_val, 8'h00);
        $display("done sources");
    end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_ext;
        t_lat;
        t_src;
        close_out;
    end
endmodule
bind cpu_interrupt_logic cpu_interrupt_logic_monitor i_mon (.clk_sys, .rst_n, .reg_rd,
    .reg_rdata, .core_sleeping, .irq_accept, .return_pc, .irq_request_r, .wake_r,
    .vector_load_r, .vector_pc_r, .stack_push_r, .stack_push_pc_r);
`default_nettype wire
